// >>> verilog/diff_adc_serial_readout.sv
// Serial readout sequencer of a 13-bit differential converter, plus its result FIFO.
// Assumes selB and sclk are synchronous to clock and far slower than it; the analog
// front end delivers signed differential samples in LSB units on rawIn/rawValid.
// Output pins are registered; doutEn high means the data pin is driven.
//
// Behaviour
// RQ1: Result is sign plus twelve bits, two's complement.
// RQ2: Negative difference gives sign one, complemented data.
// RQ3: Positive results saturate at +4095.
// RQ4: Negative results saturate at -4096.
// RQ5: Equal inputs give all-zero code.
// RQ6: Frame starts only on select falling edge.
// RQ7: Sampling starts at first rising clock.
// RQ8: Second falling edge drives low null bit.
// RQ9: Next thirteen clocks send sign, then MSB-first data.
// RQ10: Data output changes only on falling edges.
// RQ11: Further clocks resend result LSB first.
// RQ12: LSB-first data begins by falling edge sixteen.
// RQ13: After LSB-first copy, zeros indefinitely.
// RQ14: Output high impedance for first two clocks.
// RQ15: Host supplies sixteen clocks per conversion.
// RQ16: Host latches data on rising clock edges.
// RQ17: Two bytes: two undefined, null, sign, data.
// RQ18: One result bit resolved per received clock.
// RQ19: Host keeps clock at least 85 kHz.
// RQ20: Raising select aborts frame and releases output.
`timescale 1ns/1ps

// ==========================================================
// Result FIFO
module result_fifo #(
    parameter int WIDTH = adc_readout_pkg::RES_W,
    parameter int DEPTH = adc_readout_pkg::FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic inValid,
    input wire logic [WIDTH-1:0] inData,
    output logic inReady,
    output logic outValid,
    output logic [WIDTH-1:0] outData,
    input wire logic outReady
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wrPtr, next_wrPtr, rdPtr, next_rdPtr;
    logic [CNT_W-1:0] count, next_count;
    logic next_inReady;
    logic doWrite, doRead;

    always_comb begin
        doWrite = inValid && inReady;
        doRead = outValid && outReady;
        next_wrPtr = wrPtr;
        next_rdPtr = rdPtr;
        next_count = count;
        if (doWrite) begin
            next_wrPtr = (wrPtr == PTR_LAST) ? '0 : wrPtr + PTR_W'(1);
        end
        if (doRead) begin
            next_rdPtr = (rdPtr == PTR_LAST) ? '0 : rdPtr + PTR_W'(1);
        end
        // A write and a read in one cycle leave the count as it is
        if (doWrite && !doRead) begin
            next_count = count + CNT_W'(1);
        end else if (doRead && !doWrite) begin
            next_count = count - CNT_W'(1);
        end
        // Ready is registered so the source sees back-pressure straight from a flop
        next_inReady = (next_count != CNT_FULL);
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
            inReady <= 1'b1;
        end else begin
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
            count <= next_count;
            inReady <= next_inReady;
        end
    end

    // Storage has no reset; outValid guards every read of it
    always_ff @(posedge clock) begin
        if (doWrite) begin
            mem[wrPtr] <= inData;
        end
    end

    assign outValid = (count != '0);
    assign outData = mem[rdPtr];

endmodule : result_fifo

// ==========================================================
// Readout sequencer
module diff_adc_serial_readout #(
    parameter int FIFO_DEPTH = adc_readout_pkg::FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic selB,
    input wire logic sclk,
    output logic dout,
    output logic doutEn,
    output logic sampleStart,
    input wire logic rawValid,
    input wire logic signed [adc_readout_pkg::RAW_W-1:0] rawIn,
    output logic rawReady
);
    // Pick the bit driven after the given falling edge of the frame
    function automatic logic bitAt(input logic [12:0] word, input logic [4:0] fall);
        logic [4:0] idx;
        idx = '0;
        bitAt = 1'b0;
        if (fall >= adc_readout_pkg::FALL_SIGN && fall <= adc_readout_pkg::FALL_MSB_LAST) begin
            idx = adc_readout_pkg::MSB_BASE - fall;
            bitAt = word[idx[3:0]]; // [RQ9]
        end else if (fall >= adc_readout_pkg::FALL_LSB_FIRST && fall <= adc_readout_pkg::FALL_LSB_LAST) begin
            // LSB was just sent as the last MSB-first bit, so the reverse copy starts at bit one
            idx = fall - adc_readout_pkg::MSB_BASE;
            bitAt = word[idx[3:0]]; // [RQ11] [RQ12]
        end
        // Null bit and the trailing zeros both fall through as zero [RQ8] [RQ13]
    endfunction : bitAt

    // Edge seen between two successive samples of a slow pin
    function automatic logic pinRose(input logic prev, input logic cur);
        pinRose = !prev && cur;
    endfunction : pinRose

    function automatic logic pinFell(input logic prev, input logic cur);
        pinFell = prev && !cur;
    endfunction : pinFell

    // Word in force after this clock: a fresh FIFO word when popped, else the held one
    function automatic adc_readout_pkg::result_s pickWord(input logic pop, input adc_readout_pkg::result_s fresh,
        input adc_readout_pkg::result_s held);
        pickWord = pop ? fresh : held;
    endfunction : pickWord

    // Clamp a raw difference onto the thirteen-bit code range
    function automatic adc_readout_pkg::result_s saturate(input logic signed [adc_readout_pkg::RAW_W-1:0] raw);
        if (raw > adc_readout_pkg::RAW_MAX) begin
            saturate = adc_readout_pkg::CODE_POS_FULL; // [RQ3]
        end else if (raw < adc_readout_pkg::RAW_MIN) begin
            saturate = adc_readout_pkg::CODE_NEG_FULL; // [RQ4]
        end else begin
            // Two's complement truncation keeps sign and twelve data bits [RQ1] [RQ2] [RQ5]
            saturate = raw[adc_readout_pkg::RES_W-1:0];
        end
    endfunction : saturate

    // ==========================================================
    // Saturating encoder in front of the FIFO
    adc_readout_pkg::result_s clamped;
    adc_readout_pkg::result_s fifoWord;
    logic fifoValid;
    logic fifoPop;

    always_comb begin
        clamped = saturate(rawIn);
    end

    // Four words of slack let the converter run ahead of a slow host
    result_fifo #(
        .WIDTH(adc_readout_pkg::RES_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .rst_b(rst_b),
        .inValid(rawValid),
        .inData(clamped),
        .inReady(rawReady),
        .outValid(fifoValid),
        .outData(fifoWord),
        .outReady(fifoPop)
    );

    // ==========================================================
    // Pin edge detectors
    logic selPrev, next_selPrev;
    logic sclkPrev, next_sclkPrev;
    logic selFall, sclkRise, sclkFall;

    always_comb begin
        // Pins are compared sample to sample; the host keeps each phase at least two clocks long
        next_selPrev = selB;
        next_sclkPrev = sclk;
        selFall = pinFell(selPrev, selB);
        sclkRise = pinRose(sclkPrev, sclk);
        sclkFall = pinFell(sclkPrev, sclk);
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            // Starting low means a select already low at reset shows no falling edge [RQ6]
            selPrev <= 1'b0;
            // A clock idling high shows a false rise after reset, which only an armed frame could see
            sclkPrev <= 1'b0;
        end else begin
            selPrev <= next_selPrev;
            sclkPrev <= next_sclkPrev;
        end
    end

    // ==========================================================
    // Held result word
    // Reloaded only at the null bit; an empty FIFO then leaves the last code in place,
    // so a slow converter repeats a result rather than stalling the frame
    adc_readout_pkg::result_s word, next_word;

    always_comb begin
        next_word = pickWord(fifoPop, fifoWord, word);
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            word <= adc_readout_pkg::CODE_RESET;
        end else begin
            word <= next_word;
        end
    end

    // ==========================================================
    // Frame sequencer
    adc_readout_pkg::seq_state_e state, next_state;
    logic [adc_readout_pkg::COUNT_W-1:0] fallCount, next_fallCount;
    logic next_dout, next_doutEn, next_sampleStart;

    always_comb begin
        next_state = state;
        next_fallCount = fallCount;
        next_dout = dout;
        next_doutEn = doutEn;
        next_sampleStart = 1'b0;
        fifoPop = 1'b0;
        if (selB) begin
            // Abort in any phase and release the line [RQ20]
            next_state = adc_readout_pkg::ST_IDLE;
            next_fallCount = '0;
            next_dout = 1'b0;
            next_doutEn = 1'b0;
        end else begin
            unique case (state)
                adc_readout_pkg::ST_IDLE: begin
                    // Select held low since reset never opens a frame [RQ6]
                    if (selFall) begin
                        next_state = adc_readout_pkg::ST_ARMED;
                        next_fallCount = '0;
                    end
                end
                adc_readout_pkg::ST_ARMED: begin
                    // In idle-high mode the first edge is falling and is ignored
                    if (sclkRise) begin
                        next_state = adc_readout_pkg::ST_ACTIVE;
                        next_sampleStart = 1'b1; // [RQ7]
                    end
                end
                adc_readout_pkg::ST_ACTIVE: begin
                    if (sclkFall) begin // [RQ10]
                        // Count stops at the zero tail so clocks may run on without limit
                        if (fallCount != adc_readout_pkg::FALL_ZEROS) begin
                            next_fallCount = fallCount + 5'h01; // [RQ18]
                        end
                        if (next_fallCount == adc_readout_pkg::FALL_NULL) begin
                            // Sample period ends here; an empty FIFO repeats the last result
                            fifoPop = fifoValid;
                            next_doutEn = 1'b1; // [RQ14] [RQ17]
                        end
                        next_dout = bitAt(pickWord(fifoPop, fifoWord, word), next_fallCount);
                    end
                end
                default: begin
                    // An illegal state code falls back to idle with the pin released
                    next_state = adc_readout_pkg::ST_IDLE;
                    next_doutEn = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state <= adc_readout_pkg::ST_IDLE;
            fallCount <= '0;
            dout <= 1'b0;
            doutEn <= 1'b0;
            sampleStart <= 1'b0;
        end else begin
            state <= next_state;
            fallCount <= next_fallCount;
            dout <= next_dout;
            doutEn <= next_doutEn;
            sampleStart <= next_sampleStart;
        end
    end

endmodule : diff_adc_serial_readout

// >>> verilog/adc_readout_pkg.sv
// Constants and types shared by the serial readout sequencer of the differential converter.
// Assumes a single 100 MHz clock domain; pin levels arrive already synchronous to it.
package adc_readout_pkg;

    // ==========================================================
    // Result format
    localparam int RAW_W = 14;
    localparam int DATA_W = 12;
    localparam int RES_W = 13;
    localparam logic signed [13:0] RAW_MAX = 14'sh0fff;
    localparam logic signed [13:0] RAW_MIN = 14'sh3000;
    localparam logic [12:0] CODE_POS_FULL = 13'h0fff;
    localparam logic [12:0] CODE_NEG_FULL = 13'h1000;
    localparam logic [12:0] CODE_RESET = 13'h0000;

    typedef struct packed {
        logic sign;
        logic [11:0] data;
    } result_s;

    // ==========================================================
    // Falling-edge numbering within a frame
    localparam int COUNT_W = 5;
    localparam logic [4:0] FALL_NULL = 5'h02;
    localparam logic [4:0] FALL_SIGN = 5'h03;
    localparam logic [4:0] FALL_MSB_LAST = 5'h0f;
    localparam logic [4:0] FALL_LSB_FIRST = 5'h10;
    localparam logic [4:0] FALL_LSB_LAST = 5'h1b;
    localparam logic [4:0] FALL_ZEROS = 5'h1c;
    localparam logic [4:0] MSB_BASE = 5'h0f;

    // ==========================================================
    // Buffering and sequencer states
    localparam int FIFO_DEPTH = 4;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ARMED = 3'b010,
        ST_ACTIVE = 3'b100
    } seq_state_e;

endpackage : adc_readout_pkg

// >>> bench/adc_readout_properties.sv
// Pin-level checker for the readout sequencer.
// Assumes it is bound to the top module and that sclk is slow against clock.
`timescale 1ns/1ps
module adc_readout_properties #(
    parameter int FIFO_DEPTH = adc_readout_pkg::FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic selB,
    input wire logic sclk,
    input wire logic dout,
    input wire logic doutEn,
    input wire logic sampleStart,
    input wire logic rawValid,
    input wire logic signed [13:0] rawIn,
    input wire logic rawReady
);
    // ==========================================================
    // Frame tracking
    logic sPrev, selPrev, inFrame, riseSeen;
    logic [4:0] fallCnt;
    // A select already low at reset release opens no frame
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sPrev <= 1'b0;
            selPrev <= 1'b0;
            inFrame <= 1'b0;
            riseSeen <= 1'b0;
            fallCnt <= 5'h00;
        end else begin
            sPrev <= sclk;
            selPrev <= selB;
            inFrame <= !selB && (inFrame || selPrev);
            riseSeen <= !selB && inFrame && (riseSeen || (sclk && !sPrev));
            if (selB || !inFrame) begin
                fallCnt <= 5'h00;
            end else if (riseSeen && !sclk && sPrev && fallCnt != 5'h1f) begin
                fallCnt <= fallCnt + 5'h01;
            end
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    AST_STABLE_HIGH: assert property (doutEn && sclk && $past(sclk) && $past(sclk, 2) |-> $stable(dout))
        else $error("dout moved while sclk high");
    AST_ABORT_RELEASE: assert property ($rose(selB) |-> ##[1:3] !doutEn)
        else $error("abort kept output driven");
    AST_NO_FRAME_HIZ: assert property (!inFrame && !$past(inFrame) && !$past(inFrame, 2) |-> !doutEn)
        else $error("output driven outside a frame");
    AST_ENABLE_AT_NULL: assert property ($rose(doutEn) |-> fallCnt == 5'h02 && !dout)
        else $error("drive did not start with null at fall two");
    AST_ENABLE_HELD: assert property (inFrame && !selB && fallCnt >= 5'h03 |-> doutEn)
        else $error("output released mid frame");
    AST_SAMPLE_ONCE: assert property (sampleStart |=> !sampleStart)
        else $error("sample pulse too long");
    AST_SAMPLE_CAUSE: assert property ($rose(riseSeen) |-> ##[0:2] sampleStart)
        else $error("no sample pulse after first rise");
    AST_SAMPLE_IN_FRAME: assert property (sampleStart |-> inFrame && fallCnt == 5'h00)
        else $error("sample pulse outside frame start");
    AST_ZERO_TAIL: assert property (doutEn && fallCnt >= 5'h1d |-> !dout)
        else $error("tail bit not zero");
endmodule : adc_readout_properties

bind diff_adc_serial_readout adc_readout_properties #(.FIFO_DEPTH(FIFO_DEPTH)) u_props (.clock(clock),
    .rst_b(rst_b), .selB(selB), .sclk(sclk), .dout(dout), .doutEn(doutEn), .sampleStart(sampleStart),
    .rawValid(rawValid), .rawIn(rawIn), .rawReady(rawReady));

// >>> bench/spi_host_model.sv
// Host SPI controller model: drives select and serial clock, latches data.
// Assumes calls start just after a falling bench clock edge.
`timescale 1ns/1ps
module spi_host_model (
    input wire logic clock,
    input wire logic dout,
    input wire logic doutEn,
    output logic selB,
    output logic sclk
);
    logic [31:0] cap;
    logic [31:0] enCap;
    // Select low from power-up, so the first frame must be refused
    initial begin
        selB = 1'b0;
        sclk = 1'b0;
    end
    // Four bench clocks per half period keep edges visible to the sampler, far above 85 kHz
    task automatic half();
        repeat (4) @(negedge clock);
    endtask : half
    task automatic frame(input int n, input bit idleHigh);
        cap = '0;
        enCap = '0;
        sclk = idleHigh;
        half();
        selB = 1'b0;
        half();
        for (int i = 0; i < n; i++) begin
            if (idleHigh) begin
                sclk = 1'b0;
                half();
            end
            sclk = 1'b1;
            // A released line shows the inverse of the dout register, so stale data cannot pass
            cap = {cap[30:0], doutEn ? dout : !dout};
            enCap = {enCap[30:0], doutEn};
            half();
            if (!idleHigh) begin
                sclk = 1'b0;
                half();
            end
        end
        selB = 1'b1;
        half();
    endtask : frame
endmodule : spi_host_model

// >>> bench/testbench.sv
// Self-checking bench for the readout sequencer and its result FIFO.
// Assumes the host model and the bound checker.
`timescale 1ns/1ps
module testbench;
    logic clock;
    logic rst_b;
    logic rawValid;
    logic signed [13:0] rawIn;
    logic selB, sclk, dout, doutEn, sampleStart, rawReady;
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;
    int starts = 0;
    logic signed [13:0] vals [8] = '{14'sh0000, 14'sh3fff, 14'sh1388, 14'sh2c78,
        14'sh0fff, 14'sh3000, 14'sh3ffe, 14'sh0002};
    diff_adc_serial_readout u_dut (.clock(clock), .rst_b(rst_b), .selB(selB), .sclk(sclk), .dout(dout),
        .doutEn(doutEn), .sampleStart(sampleStart), .rawValid(rawValid), .rawIn(rawIn), .rawReady(rawReady));
    spi_host_model u_host (.clock(clock), .dout(dout), .doutEn(doutEn), .selB(selB), .sclk(sclk));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict
    // Ceiling is more than ten times the expected run of about 1500 cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            print_verdict();
        end
    end
    // Sample pulses are counted on the falling edge, where the registered pulse has settled
    always @(negedge clock) begin
        if (sampleStart === 1'b1) begin
            starts++;
        end
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic push(input logic signed [13:0] v);
        @(negedge clock);
        check("room", rawReady, 1'b1);
        rawValid = 1'b1;
        rawIn = v;
        @(negedge clock);
        rawValid = 1'b0;
    endtask : push
    task automatic run_frame(input logic signed [13:0] v, input int n, input bit idleHigh);
        logic [12:0] code;
        logic [11:0] rev;
        logic [31:0] word;
        int startsBefore;
        code = (v > 14'sh0fff) ? 13'h0fff : (v < 14'sh3000) ? 13'h1000 : v[12:0];
        rev = {<<{code[12:1]}};
        startsBefore = starts;
        u_host.frame(n, idleHigh);
        check("sample start", starts - startsBefore, 32'h1);
        word = u_host.cap >> (n - 16);
        check("msb word", word[13:0], {1'b0, code});
        check("enable", u_host.enCap[n-1 -: 3], 3'b001);
        check("released", doutEn, 1'b0);
        if (n > 16) begin
            check("lsb copy", u_host.cap[15:4], rev);
            check("zeros", u_host.cap[3:0], 4'h0);
        end
    endtask : run_frame
    task automatic test_stale();
        u_host.frame(16, 1'b0);
        check("stale", u_host.enCap, 32'h0);
        check("stale line", u_host.cap, 32'h0000ffff);
        check("stale start", starts, 32'h0);
        $display("test stale done");
    endtask : test_stale
    task automatic test_codes();
        for (int i = 0; i < 4; i++) push(vals[i]);
        repeat (2) @(negedge clock);
        check("full", rawReady, 1'b0);
        for (int i = 0; i < 4; i++) run_frame(vals[i], 16, i[0]);
        $display("test codes done");
    endtask : test_codes
    task automatic test_long();
        for (int i = 4; i < 8; i++) push(vals[i]);
        run_frame(vals[4], 32, 1'b0);
        // Aborted frame still consumes its word at the null bit
        u_host.frame(6, 1'b1);
        check("abort", doutEn, 1'b0);
        run_frame(vals[6], 16, 1'b1);
        run_frame(vals[7], 16, 1'b0);
        run_frame(vals[7], 16, 1'b1);
        $display("test long done");
    endtask : test_long
    initial begin
        rst_b = 1'b0;
        rawValid = 1'b0;
        rawIn = '0;
        repeat (6) @(negedge clock);
        rst_b = 1'b1;
        check("ready", rawReady, 1'b1);
        check("hiz", doutEn, 1'b0);
        $display("test reset done");
        test_stale();
        test_codes();
        test_long();
        print_verdict();
    end
endmodule : testbench
